// File: bench/toc_compare_unit_tb.sv
// Purpose: Self-checking bench for the timer output compare unit
// Assumes: Inputs change on the falling clock edge
// Notes:   Each timer tick is followed by two idle system cycles
`timescale 1ns/1ps
module toc_compare_unit_tb;
	import toc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        tick = 1'b0;
	logic [2:0]  clk_sel = 3'h1;
	logic [3:0]  mode = 4'h0;
	logic [15:0] cap = 16'h0;
	logic [1:0]  out_mode [2] = '{2'h0, 2'h0};
	logic [1:0]  frc = 0, irq_en = 0, fwr = 0, fwd = 0, ack = 0;
	logic [1:0]  port = 0, dir = 0;
	logic        ov_ack = 1'b0;
	logic [7:0]  wd;
	logic [2:0]  wh, wl;
	wire  [15:0] cnt, va, vb;
	wire  [1:0]  flag, irq, st, pv, pd;
	wire         ovf;
	int          fails = 0, checked = 0, cyc = 0, ch;
	logic [31:0] seed = 32'h646f;
	logic [15:0] v;
	logic        s;
	toc_compare_unit u_toc_compare_unit (
		.i_clock(clk), .i_rst_b(rst_b), .i_timer_tick(tick),
		.i_clock_select(clk_sel), .i_waveform_mode(mode),
		.i_capture_value(cap), .i_wr_data(wd),
		.i_cnt_wr_high(wh[0]), .i_cnt_wr_low(wl[0]),
		.i_cmp_a_wr_high(wh[1]), .i_cmp_a_wr_low(wl[1]),
		.i_cmp_b_wr_high(wh[2]), .i_cmp_b_wr_low(wl[2]),
		.i_compare_output_mode_a(out_mode[0]),
		.i_compare_output_mode_b(out_mode[1]),
		.i_force_compare_strobe(frc), .i_compare_irq_enable(irq_en),
		.i_overflow_irq_enable(1'b1), .i_flag_wr(fwr),
		.i_flag_wr_data(fwd), .i_irq_ack(ack), .i_overflow_ack(ov_ack),
		.i_port_value(port), .i_pin_direction_bit(dir),
		.o_timer_count(cnt), .o_compare_value_a(va),
		.o_compare_value_b(vb), .o_compare_match_flag(flag),
		.o_overflow_flag(ovf), .o_compare_irq(irq), .o_overflow_irq(),
		.o_compare_output_state(st), .o_pin_value(pv), .o_pin_drive(pd)
	);
	toc_cpu_model u_toc_cpu_model (
		.i_clock(clk), .o_wr_data(wd), .o_wr_high(wh), .o_wr_low(wl)
	);
	// 250 MHz system clock
	initial begin
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs
	// Expected output state after one match
	function automatic logic act(input logic [1:0] m, input logic q);
		if (m == COM_TOGGLE) return !q;
		if (m == COM_CLEAR) return 1'b0;
		if (m == COM_SET) return 1'b1;
		return q;
	endfunction : act
	task automatic chk(input logic [15:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Idle gap lets the one-cycle-late outputs settle
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk);
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
			@(negedge clk);
		end
	endtask : ticks
	task automatic flag_op(input int c, input logic by_ack, input logic d);
		@(negedge clk);
		fwd = {2{d}};
		if (by_ack) ack[c] = 1'b1;
		else fwr[c] = 1'b1;
		@(negedge clk);
		fwr = 2'b00;
		ack = 2'b00;
		@(negedge clk);
	endtask : flag_op
	task automatic force_a();
		@(negedge clk);
		frc = 2'b01;
		@(negedge clk);
		frc = 2'b00;
		@(negedge clk);
	endtask : force_a
	task complete_run();
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		chk(16'(st), 16'h0, "reset state");
		for (int i = 0; i < 8; i++) begin
			ch = i % 2;
			seed = xs(seed);
			v = seed[15:0] | 16'h0100;
			out_mode[ch] = 2'(i / 2);
			irq_en = seed[17:16];
			u_toc_cpu_model.write16(ch + 1, v);
			u_toc_cpu_model.write16(0, v - 16'h2);
			ticks(2);
			s = st[ch];
			ticks(1);
			chk(16'(flag[ch]), 16'h0, "early flag");
			chk(16'(st[ch]), 16'(act(out_mode[ch], s)), "state");
			ticks(1);
			chk(16'(flag[ch]), 16'h1, "match flag");
			chk(16'(irq[ch]), 16'(irq_en[ch]), "irq");
			flag_op(ch, 1'b0, 1'b0);
			chk(16'(flag[ch]), 16'h1, "zero write");
			flag_op(ch, i[1], 1'b1);
			chk(16'(flag[ch]), 16'h0, "flag clear");
		end
		clk_sel = CS_STOPPED;
		out_mode[0] = COM_TOGGLE;
		u_toc_cpu_model.write16(1, 16'h4000);
		u_toc_cpu_model.write16(0, 16'h4000);
		ticks(2);
		chk(cnt, 16'h4000, "stopped");
		clk_sel = 3'h1;
		s = st[0];
		ticks(2);
		chk(16'({flag[0], st[0]}), 16'(s), "blocked");
		force_a();
		chk(16'({flag[0], st[0]}), 16'(!s), "forced");
		chk(cnt, 16'h4002, "force count");
		mode = 4'h5;
		force_a();
		mode = MODE_NORMAL;
		chk(16'(st[0]), 16'(!s), "mode change");
		out_mode[1] = COM_NONE;
		port = seed[1:0];
		dir = 2'b11;
		repeat (3) @(negedge clk);
		chk(16'(pv), 16'({port[1], st[0]}), "pin");
		chk(16'(pd), 16'h3, "drive");
		@(negedge clk);
		ov_ack = 1'b1;
		u_toc_cpu_model.write16(0, 16'hfffe);
		ov_ack = 1'b0;
		ticks(1);
		chk(16'(ovf), 16'h0, "no overflow");
		ticks(1);
		chk({cnt[14:0], ovf}, 16'h1, "wrap");
		u_toc_cpu_model.write16(1, 16'h0005);
		cap = 16'h0003;
		for (int m = 0; m < 2; m++) begin
			mode = m ? MODE_CTC_CAP : MODE_CTC_CMP;
			u_toc_cpu_model.write16(0, 16'h0);
			for (int k = 1; k < 13; k++) begin
				ticks(1);
				chk(cnt, 16'(k % (m ? 4 : 6)), "clear on match");
			end
		end
		mode = MODE_NORMAL;
		u_toc_cpu_model.write16(2, 16'h8000);
		mode = 4'h5;
		u_toc_cpu_model.write16(2, 16'h0010);
		@(negedge clk);
		chk(vb, 16'h0010, "buffer view");
		chk(va, 16'h0005, "view a");
		flag_op(1, 1'b0, 1'b1);
		u_toc_cpu_model.write16(0, 16'h000d);
		ticks(5);
		chk(16'(flag[1]), 16'h0, "buffer held");
		u_toc_cpu_model.write16(0, 16'hfffe);
		ticks(20);
		chk(16'(flag[1]), 16'h1, "copied at top");
		complete_run();
	end
endmodule : toc_compare_unit_tb
bind toc_compare_unit toc_monitor u_toc_monitor (.*);

// File: bench/toc_cpu_model.sv
// Purpose: Byte-wide CPU writer for counter and compare values
// Assumes: Strobes are one system clock wide, driven on falling edge
// Notes:   Index 0 counter, 1 channel A, 2 channel B
`timescale 1ns/1ps
module toc_cpu_model (
	input  wire logic       i_clock,
	output logic      [7:0] o_wr_data,
	output logic      [2:0] o_wr_high,
	output logic      [2:0] o_wr_low
);
	// Idle bus at time zero
	initial begin
		o_wr_data = 8'h00;
		o_wr_high = 3'h0;
		o_wr_low  = 3'h0;
	end
	// High byte first, so both bytes land together
	task automatic write16(input int sel, input logic [15:0] value);
		@(negedge i_clock);
		o_wr_data      = value[15:8];
		o_wr_high[sel] = 1'b1;
		@(negedge i_clock);
		o_wr_high     = 3'h0;
		o_wr_data     = value[7:0];
		o_wr_low[sel] = 1'b1;
		@(negedge i_clock);
		o_wr_low  = 3'h0;
		o_wr_data = ~value[7:0]; // Released bus shows no stale byte
	endtask : write16
endmodule : toc_cpu_model

// File: bench/toc_monitor.sv
// Purpose: Port-level checks on the timer output compare unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Output state watched on channel A; B shares the logic
`timescale 1ns/1ps
module toc_monitor
	import toc_pkg::*;
(
	input wire logic        i_clock,
	input wire logic        i_rst_b,
	input wire logic        i_timer_tick,
	input wire logic [2:0]  i_clock_select,
	input wire logic [3:0]  i_waveform_mode,
	input wire logic [7:0]  i_wr_data,
	input wire logic        i_cnt_wr_low,
	input wire logic [1:0]  i_compare_output_mode_a,
	input wire logic [1:0]  i_force_compare_strobe,
	input wire logic [1:0]  i_compare_irq_enable,
	input wire logic [1:0]  i_flag_wr,
	input wire logic [1:0]  i_flag_wr_data,
	input wire logic [1:0]  i_irq_ack,
	input wire logic [1:0]  i_pin_direction_bit,
	input wire logic [15:0] o_timer_count,
	input wire logic [1:0]  o_compare_match_flag,
	input wire logic        o_overflow_flag,
	input wire logic [1:0]  o_compare_irq,
	input wire logic [1:0]  o_compare_output_state,
	input wire logic [1:0]  o_pin_value,
	input wire logic [1:0]  o_pin_drive
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// Running tick in Normal mode with no CPU load competing
	wire norm_tick = i_timer_tick && i_clock_select != 3'h0 &&
		i_waveform_mode == 4'h0 && !i_cnt_wr_low;
	property p_wrap;
		norm_tick && o_timer_count == 16'hffff
		|=> o_timer_count == 16'h0000 && o_overflow_flag;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap failed");
	property p_count;
		norm_tick && o_timer_count != 16'hffff
		|=> o_timer_count == $past(o_timer_count) + 16'h1;
	endproperty
	a_count: assert property (p_count) else $error("no step");
	property p_stop;
		i_clock_select == 3'h0 && !i_cnt_wr_low |=> $stable(o_timer_count);
	endproperty
	a_stop: assert property (p_stop) else $error("moved");
	property p_load;
		i_cnt_wr_low |=> o_timer_count[7:0] == $past(i_wr_data);
	endproperty
	a_load: assert property (p_load) else $error("load lost");
	property p_clr1;
		i_flag_wr[0] && i_flag_wr_data[0] && !i_timer_tick
		|=> !o_compare_match_flag[0];
	endproperty
	a_clr1: assert property (p_clr1) else $error("flag kept");
	property p_clr0;
		i_flag_wr[0] && !i_flag_wr_data[0] && !i_irq_ack[0] &&
		o_compare_match_flag[0] |=> o_compare_match_flag[0];
	endproperty
	a_clr0: assert property (p_clr0) else $error("flag lost");
	property p_irq;
		o_compare_irq[0]
		|-> o_compare_match_flag[0] && $past(i_compare_irq_enable[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("stray irq");
	property p_force;
		i_force_compare_strobe[0] && i_waveform_mode == 4'h0 &&
		!i_timer_tick && !i_cnt_wr_low && !o_compare_match_flag[0]
		|=> !o_compare_match_flag[0] && $stable(o_timer_count);
	endproperty
	a_force: assert property (p_force) else $error("force side");
	property p_hold;
		(i_compare_output_mode_a == 2'h0 && !i_force_compare_strobe[0])[*3]
		|-> $stable(o_compare_output_state[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved");
	property p_pin;
		(i_compare_output_mode_a != 2'h0 &&
		$stable(o_compare_output_state[0]))[*3]
		|-> o_pin_value[0] == o_compare_output_state[0];
	endproperty
	a_pin: assert property (p_pin) else $error("no override");
	property p_drive;
		$stable(i_pin_direction_bit)[*2] |-> o_pin_drive == i_pin_direction_bit;
	endproperty
	a_drive: assert property (p_drive) else $error("drive off");
	c_wrap: cover property (norm_tick && o_timer_count == 16'hffff);
	c_force: cover property (i_force_compare_strobe[0]);
	c_flag: cover property ($rose(o_compare_match_flag[0]));
endmodule : toc_monitor

// File: rtl/toc_compare_unit.sv
// Purpose: Counter, two compare channels, flags and pin override
// Assumes: i_timer_tick is a one-cycle pulse of the prescaled timer clock
// Notes:   Only Normal and clear-on-match counting; PWM modes only buffer and ignore force strobes
`timescale 1ns/1ps
module toc_compare_unit
	import toc_pkg::*;
(
	input  wire logic                       i_clock,
	input  wire logic                       i_rst_b,
	input  wire logic                       i_timer_tick,
	input  wire logic [toc_pkg::CS_W-1:0]   i_clock_select,
	input  wire logic [toc_pkg::MODE_W-1:0] i_waveform_mode,
	input  wire logic [toc_pkg::CNT_W-1:0]  i_capture_value,
	input  wire logic [toc_pkg::BYTE_W-1:0] i_wr_data,
	input  wire logic                       i_cnt_wr_high,
	input  wire logic                       i_cnt_wr_low,
	input  wire logic                       i_cmp_a_wr_high,
	input  wire logic                       i_cmp_a_wr_low,
	input  wire logic                       i_cmp_b_wr_high,
	input  wire logic                       i_cmp_b_wr_low,
	input  wire logic [toc_pkg::COM_W-1:0]  i_compare_output_mode_a,
	input  wire logic [toc_pkg::COM_W-1:0]  i_compare_output_mode_b,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_force_compare_strobe,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_compare_irq_enable,
	input  wire logic                       i_overflow_irq_enable,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_flag_wr,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_flag_wr_data,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_irq_ack,
	input  wire logic                       i_overflow_ack,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_port_value,
	input  wire logic [toc_pkg::NUM_CH-1:0] i_pin_direction_bit,
	output logic      [toc_pkg::CNT_W-1:0]  o_timer_count,
	output logic      [toc_pkg::CNT_W-1:0]  o_compare_value_a,
	output logic      [toc_pkg::CNT_W-1:0]  o_compare_value_b,
	output logic      [toc_pkg::NUM_CH-1:0] o_compare_match_flag,
	output logic                            o_overflow_flag,
	output logic      [toc_pkg::NUM_CH-1:0] o_compare_irq,
	output logic                            o_overflow_irq,
	output logic      [toc_pkg::NUM_CH-1:0] o_compare_output_state,
	output logic      [toc_pkg::NUM_CH-1:0] o_pin_value,
	output logic      [toc_pkg::NUM_CH-1:0] o_pin_drive
);
	logic [CNT_W-1:0]  timer_count;
	logic [BYTE_W-1:0] temp_high;
	logic              block_pending;
	logic [NUM_CH-1:0] match_seen;
	logic [NUM_CH-1:0] match_flag;
	logic              overflow_flag;
	logic [NUM_CH-1:0] irq_q;
	logic              ovf_irq_q;
	logic [NUM_CH-1:0] state_q;
	logic [NUM_CH-1:0] pin_q;
	logic [NUM_CH-1:0] drive_q;
	logic [CNT_W-1:0]  active_val [NUM_CH];
	logic [CNT_W-1:0]  cpu_view   [NUM_CH];
	logic [NUM_CH-1:0] ch_state;
	logic [NUM_CH-1:0] ch_pin;
	logic [CNT_W-1:0]  next_count;
	toc_cnt_op_t       cnt_op;

	// Mode decode: only modes 0, 4, 12 and reserved 13 are unbuffered
	wire is_normal   = (i_waveform_mode == MODE_NORMAL);
	wire is_ctc_a    = (i_waveform_mode == MODE_CTC_CMP);
	wire is_ctc_cap  = (i_waveform_mode == MODE_CTC_CAP);
	wire non_pwm     = is_normal | is_ctc_a | is_ctc_cap
	                 | (i_waveform_mode == MODE_RESERVED);
	wire buffered    = ~non_pwm;
	wire running     = (i_clock_select != CS_STOPPED);
	wire tick        = i_timer_tick & running;
	wire cnt_write   = i_cnt_wr_low;
	wire at_bottom   = (timer_count == CNT_BOTTOM);
	wire at_top      = is_ctc_a ? (timer_count == active_val[CH_A])
	                            : (timer_count == CNT_MAX);

	// Raw comparators on every counter bit
	wire [NUM_CH-1:0] raw_match;
	wire [NUM_CH-1:0] wr_low  = {i_cmp_b_wr_low, i_cmp_a_wr_low};
	wire [NUM_CH-1:0] wr_high = {i_cmp_b_wr_high, i_cmp_a_wr_high};
	wire [COM_W-1:0]  com_mode [NUM_CH];
	assign com_mode[CH_A] = i_compare_output_mode_a;
	assign com_mode[CH_B] = i_compare_output_mode_b;

	// Per-channel compare value, comparator and output state
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
			toc_compare_value u_value (
				.i_clock     (i_clock),
				.i_rst_b     (i_rst_b),
				.i_buffered  (buffered),
				.i_wr_low    (wr_low[ch]),
				.i_wr_data   (i_wr_data),
				.i_temp_high (temp_high),
				.i_update    (tick & (at_top | at_bottom)),
				.o_active    (active_val[ch]),
				.o_cpu_view  (cpu_view[ch])
			);
			assign raw_match[ch] = (timer_count == active_val[ch]);
			toc_output_state u_state (
				.i_clock       (i_clock),
				.i_rst_b       (i_rst_b),
				.i_match_event (tick & raw_match[ch] & ~block_pending),
				.i_force       (i_force_compare_strobe[ch] & non_pwm),
				.i_output_mode (com_mode[ch]),
				.i_port_value  (i_port_value[ch]),
				.o_state       (ch_state[ch]),
				.o_pin_value   (ch_pin[ch])
			);
		end
	endgenerate

	// Gated matches: a counter write blocks the next tick's matches
	wire [NUM_CH-1:0] match_ok = raw_match & {NUM_CH{~block_pending}};
	wire ctc_clear = (is_ctc_a & match_ok[CH_A])
	               | (is_ctc_cap & (timer_count == i_capture_value));

	// Counter step choice; CPU write beats clear and count
	always_comb begin
		cnt_op     = toc_cnt_hold;
		next_count = timer_count;
		if (cnt_write) begin
			next_count = {temp_high, i_wr_data};
		end else if (tick) begin
			cnt_op = ctc_clear ? toc_cnt_clear : toc_cnt_inc;
			case (cnt_op)
				toc_cnt_clear: next_count = CNT_RESET;
				toc_cnt_inc:   next_count = timer_count + 16'h0001;
				default:       next_count = timer_count;
			endcase
		end
	end

	// Counter and shared temporary high byte
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			timer_count <= CNT_RESET;
			temp_high   <= TEMP_RESET;
		end else begin
			timer_count <= next_count;
			if (i_cnt_wr_high | (|wr_high))
				temp_high <= i_wr_data;
		end
	end

	// Blocking lasts until the next tick, even with the clock stopped
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			block_pending <= 1'b0;
		else if (cnt_write)
			block_pending <= 1'b1;
		else if (tick)
			block_pending <= 1'b0;
	end

	// Match seen on one tick sets the flag on the next tick
	wire [NUM_CH-1:0] flag_set = match_seen & {NUM_CH{tick}};
	wire [NUM_CH-1:0] flag_clr = (i_flag_wr & i_flag_wr_data)
	                           | i_irq_ack;
	wire ovf_set = tick & ~cnt_write & (next_count == CNT_BOTTOM)
	             & (timer_count == CNT_MAX);

	// Flags: set wins over a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			match_seen    <= '0;
			match_flag    <= '0;
			overflow_flag <= 1'b0;
		end else begin
			if (tick)
				match_seen <= match_ok;
			match_flag    <= flag_set | (match_flag & ~flag_clr);
			overflow_flag <= ovf_set | (overflow_flag & ~i_overflow_ack);
		end
	end

	// Interrupt requests from the flag values about to be stored
	wire [NUM_CH-1:0] next_flag = flag_set | (match_flag & ~flag_clr);
	wire [NUM_CH-1:0] next_irq  = next_flag & i_compare_irq_enable;
	wire next_ovf_irq = (ovf_set | (overflow_flag & ~i_overflow_ack))
	                  & i_overflow_irq_enable;

	// Registered outputs; capture logic never sees the output mode
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_q     <= '0;
			ovf_irq_q <= 1'b0;
			state_q   <= '0;
			pin_q     <= '0;
			drive_q   <= '0;
		end else begin
			irq_q     <= next_irq;
			ovf_irq_q <= next_ovf_irq;
			state_q   <= ch_state;
			pin_q     <= ch_pin;
			drive_q   <= i_pin_direction_bit;
		end
	end

	// Compare value read-back registered for the flop-only outputs
	logic [CNT_W-1:0] view_a;
	logic [CNT_W-1:0] view_b;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			view_a <= CMP_RESET;
			view_b <= CMP_RESET;
		end else begin
			view_a <= cpu_view[CH_A];
			view_b <= cpu_view[CH_B];
		end
	end

	assign o_timer_count          = timer_count;
	assign o_compare_value_a      = view_a;
	assign o_compare_value_b      = view_b;
	assign o_compare_match_flag   = match_flag;
	assign o_overflow_flag        = overflow_flag;
	assign o_compare_irq          = irq_q;
	assign o_overflow_irq         = ovf_irq_q;
	assign o_compare_output_state = state_q;
	assign o_pin_value            = pin_q;
	assign o_pin_drive            = drive_q;
endmodule : toc_compare_unit

// File: rtl/toc_compare_value.sv
// Purpose: One channel's compare value with optional double buffer
// Assumes: Low-byte write strobe carries the shared temporary high byte
// Notes:   Buffer changes only on CPU writes, active also at TOP/BOTTOM; reads bypass the temp byte
`timescale 1ns/1ps
module toc_compare_value
	import toc_pkg::*;
(
	input  wire logic                       i_clock,
	input  wire logic                       i_rst_b,
	input  wire logic                       i_buffered,
	input  wire logic                       i_wr_low,
	input  wire logic [toc_pkg::BYTE_W-1:0] i_wr_data,
	input  wire logic [toc_pkg::BYTE_W-1:0] i_temp_high,
	input  wire logic                       i_update,
	output logic      [toc_pkg::CNT_W-1:0]  o_active,
	output logic      [toc_pkg::CNT_W-1:0]  o_cpu_view
);
	logic [CNT_W-1:0] buffer_value;
	logic [CNT_W-1:0] active_value;
	wire  [CNT_W-1:0] write_word = {i_temp_high, i_wr_data};
	wire              wr_buffer  = i_wr_low & i_buffered;
	wire              wr_direct  = i_wr_low & ~i_buffered;

	// Buffer catches every CPU write, whether double buffering is on or off
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			buffer_value <= CMP_RESET;
		else if (wr_buffer)
			buffer_value <= write_word;
		else if (wr_direct)
			buffer_value <= write_word;
	end

	// Active value: direct write or transfer at TOP/BOTTOM
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			active_value <= CMP_RESET;
		else if (wr_direct)
			active_value <= write_word;
		else if (i_buffered && i_update)
			active_value <= buffer_value;
	end

	assign o_active   = active_value;
	// Read straight from the buffer/register, never via temp
	assign o_cpu_view = i_buffered ? buffer_value : active_value;
endmodule : toc_compare_value

// File: rtl/toc_output_state.sv
// Purpose: Output compare state bit and pin override of one channel
// Assumes: Match and force pulses are one system clock wide
// Notes:   State is kept across mode changes; reset, or a match or force in clear mode, clears it
`timescale 1ns/1ps
module toc_output_state
	import toc_pkg::*;
(
	input  wire logic                      i_clock,
	input  wire logic                      i_rst_b,
	input  wire logic                      i_match_event,
	input  wire logic                      i_force,
	input  wire logic [toc_pkg::COM_W-1:0] i_output_mode,
	input  wire logic                      i_port_value,
	output logic                           o_state,
	output logic                           o_pin_value
);
	logic state;
	logic next_state;
	wire  act = i_match_event | i_force;

	// Mode setting read live, not buffered with the compare value
	always_comb begin
		next_state = state;
		if (act) begin
			case (i_output_mode)
				COM_NONE:   next_state = state;
				COM_TOGGLE: next_state = ~state;
				COM_CLEAR:  next_state = 1'b0;
				COM_SET:    next_state = 1'b1;
				default:    next_state = state;
			endcase
		end
	end

	// Mode only selects the action on a match or force, so a mode change alone cannot disturb it
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			state <= OUT_RESET;
		else
			state <= next_state;
	end

	assign o_state     = state;
	// Any nonzero mode hands the pin to the compare state
	assign o_pin_value = (i_output_mode != COM_NONE) ? state
	                                                 : i_port_value;
endmodule : toc_output_state

// File: shared/toc_pkg.sv
// Purpose: Constants and types for the 16-bit timer output compare unit
// Assumes: Byte-wide CPU strobes, one system clock, timer tick as enable input
// Notes:   Mode codes follow the waveform_mode encoding of the timer
package toc_pkg;
	localparam int          CNT_W          = 16;
	localparam int          BYTE_W         = 8;
	localparam int          NUM_CH         = 2;
	localparam int          MODE_W         = 4;
	localparam int          COM_W          = 2;
	localparam int          CS_W           = 3;
	localparam int          CH_A           = 0;
	localparam int          CH_B           = 1;
	localparam logic [15:0] CNT_RESET      = 16'h0000;
	localparam logic [15:0] CNT_MAX        = 16'hffff;
	localparam logic [15:0] CNT_BOTTOM     = 16'h0000;
	localparam logic [15:0] CMP_RESET      = 16'h0000;
	localparam logic [7:0]  TEMP_RESET     = 8'h00;
	localparam logic        OUT_RESET      = 1'b0;
	localparam logic [2:0]  CS_STOPPED     = 3'h0;
	localparam logic [3:0]  MODE_NORMAL    = 4'h0;
	localparam logic [3:0]  MODE_CTC_CMP   = 4'h4;
	localparam logic [3:0]  MODE_CTC_CAP   = 4'hc;
	localparam logic [3:0]  MODE_RESERVED  = 4'hd;
	localparam logic [1:0]  COM_NONE       = 2'h0;
	localparam logic [1:0]  COM_TOGGLE     = 2'h1;
	localparam logic [1:0]  COM_CLEAR      = 2'h2;
	localparam logic [1:0]  COM_SET        = 2'h3;
	// Counter step choices made once per timer tick
	typedef enum logic [1:0] {
		toc_cnt_hold,
		toc_cnt_inc,
		toc_cnt_clear
	} toc_cnt_op_t;
endpackage : toc_pkg
